// >>> hw/trf_regs.vh
// Register offsets, field positions, reset values and encoding constants of the formatter
`ifndef TRF_REGS_VH
`define TRF_REGS_VH
`define TRF_OFS_CONFIG 12'h000
`define TRF_OFS_RESOL 12'h004
`define TRF_OFS_LOC_RESULT 12'h008
`define TRF_OFS_REM_RESULT 12'h00C
`define TRF_OFS_ALARM_LIM 12'h010
`define TRF_OFS_THERMAL_FLAG_OUTPUT_LIM 12'h014
`define TRF_OFS_STATUS 12'h018
`define TRF_OFS_MASK 12'h01C
`define TRF_CFG_RANGE_BIT 2
`define TRF_CFG_RESET 8'h00
`define TRF_RESOL_RESET 2'h3
`define TRF_ALARM_LIM_RESET 32'h0000FF00
`define TRF_THERMAL_FLAG_OUTPUT_LIM_RESET 16'h7F7F
`define TRF_EXT_OFFSET 13'h0040
`define TRF_STD_MAX 8'h7F
`define TRF_EXT_MAX 8'hFF
`define TRF_ZERO_BYTE 8'h00
`define TRF_RES_HALF 2'h0
`define TRF_RES_QUARTER 2'h1
`define TRF_RES_EIGHTH 2'h2
`define TRF_RES_SIXTEENTH 2'h3
`define TRF_ST_LHIGH 0
`define TRF_ST_LLOW 1
`define TRF_ST_RHIGH 2
`define TRF_ST_RLOW 3
`define TRF_ST_LTHERM 4
`define TRF_ST_RTHERM 5
`define TRF_ST_CONV 6
`define TRF_ST_WIDTH 7
`endif

// >>> hw/trf_formatter.v
// Temperature result formatter with APB registers, limit comparison and flag outputs
//
// Behaviour
// - Standard range: unsigned 0 to 127 degrees
// - Standard range clamps negatives to 00h
// - Standard range saturates above 127 to 7Fh
// - Config bit 2 selects extended range
// - Range change applies from next conversion
// - Extended range adds 64 to signed value
// - Extended codes span -64 to +191 degrees
// - Limits never reformatted on range change
// - Two bytes per channel, high byte whole
// - Low byte holds the fraction
// - Remote fraction fixed at sixteenth degree
// - Local fraction follows two-bit resolution select
// - Alarm on high or low limit breach
// - Thermal flag when above thermal limits
// - Flag pins only pull low or release
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "trf_regs.vh"
module trf_formatter #(
   parameter TEMP_W = 13
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire conv_clk,
   input wire conv_done,
   input wire [TEMP_W-1:0] local_temp,
   input wire [TEMP_W-1:0] remote_temp,
   output wire alarm_out,
   output wire alarm_oe,
   output wire thermal_flag_output,
   output wire thermal_flag_oe,
   output wire irq
);

////////////////////////////////////////////////////////////////////////////////
// Conversion link: clock and strobe are sampled; temps read each cycle the synced strobe is high
reg [2:0] clk_sync;
reg [1:0] done_sync;
wire conv_rise;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      clk_sync <= 3'h0;
      done_sync <= 2'h0;
   end else begin
      clk_sync <= {clk_sync[1:0], conv_clk};
      done_sync <= {done_sync[0], conv_done};
   end
end
assign conv_rise = clk_sync[1] & ~clk_sync[2];
// Strobe is a level set up well before the link edge, so its second stage suffices
wire conv_take = conv_rise & done_sync[1];

// Temps are held stable by the converter while the strobe is high
// Only the second strobe stage may qualify the capture: the first can be metastable
reg [TEMP_W-1:0] loc_hold, rem_hold;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      loc_hold <= {TEMP_W{1'b0}};
      rem_hold <= {TEMP_W{1'b0}};
   end else if (done_sync[1]) begin
      loc_hold <= local_temp;
      rem_hold <= remote_temp;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] cfg;
reg [1:0] resol;
reg [31:0] alarm_lim;
reg [15:0] thermal_flag_output_lim;
reg [`TRF_ST_WIDTH-1:0] status, mask;
reg [15:0] loc_result, rem_result;
reg range_used;

wire wr = psel & penable & pwrite;
wire rd_ok = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'h0);
assign pready = 1'b1;
assign pslverr = psel & penable & ~rd_ok;

// Decoded write strobes, one per writable register
wire wr_cfg = wr & (paddr == `TRF_OFS_CONFIG);
wire wr_resol = wr & (paddr == `TRF_OFS_RESOL);
wire wr_alarm = wr & (paddr == `TRF_OFS_ALARM_LIM);
wire wr_thermal_flag_output = wr & (paddr == `TRF_OFS_THERMAL_FLAG_OUTPUT_LIM);
wire wr_status = wr & (paddr == `TRF_OFS_STATUS);
wire wr_mask = wr & (paddr == `TRF_OFS_MASK);

// Range in force for the next capture; stored results keep their own
wire range_sel = cfg[`TRF_CFG_RANGE_BIT];

// Local resolution select field, upper and lower bit
wire local_resolution_select_hi = resol[1];
wire local_resolution_select_lo = resol[0];
wire [1:0] loc_res_sel = {local_resolution_select_hi, local_resolution_select_lo};

////////////////////////////////////////////////////////////////////////////////
// Formatting: temps are signed, 4 fraction bits
// Bias of the extended code, at the width of the temperature word
localparam [TEMP_W-1:0] EXT_OFFSET = `TRF_EXT_OFFSET;
function [7:0] trf_high;
   input [TEMP_W-1:0] t;
   input ext;
   reg [TEMP_W-1:0] w;
   reg [TEMP_W-1:0] biased;
   begin
      w = {{4{t[TEMP_W-1]}}, t[TEMP_W-1:4]};
      biased = w + EXT_OFFSET;
      if (ext) begin
         // Clamp to the code span of the extended format
         if (biased[TEMP_W-1])
            trf_high = `TRF_ZERO_BYTE;
         else if (|biased[TEMP_W-2:8])
            trf_high = `TRF_EXT_MAX;
         else
            trf_high = biased[7:0];
      end else begin
         if (w[TEMP_W-1])
            trf_high = `TRF_ZERO_BYTE;
         else if (|w[TEMP_W-2:7])
            trf_high = `TRF_STD_MAX;
         else
            trf_high = w[7:0];
      end
   end
endfunction

// Values clamped below the span carry a zero fraction; values saturated high keep theirs
function [7:0] trf_low;
   input [TEMP_W-1:0] t;
   input [7:0] hi;
   input ext;
   input [1:0] res;
   reg [3:0] f;
   begin
      f = t[3:0];
      case (res)
         `TRF_RES_HALF: f = {f[3], 3'h0};
         `TRF_RES_QUARTER: f = {f[3:2], 2'h0};
         `TRF_RES_EIGHTH: f = {f[3:1], 1'h0};
         default: f = f;
      endcase
      // Below the code span: standard below zero, extended below the bias
      // A value just under zero in extended range still keeps its fraction
      if (hi == `TRF_ZERO_BYTE) begin
         if (ext) begin
            if (t[TEMP_W-1] & ~(t[TEMP_W-2] & t[TEMP_W-3]))
               f = 4'h0;
         end else begin
            if (t[TEMP_W-1])
               f = 4'h0;
         end
      end
      if ((!ext && hi == `TRF_STD_MAX) || (ext && hi == `TRF_EXT_MAX))
         f = t[3:0] & f;
      trf_low = {f, 4'h0};
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Per-channel formatting: index 0 is local, index 1 is remote
localparam CH_LOC = 0;
localparam CH_REM = 1;
localparam CH_NUM = 2;

wire [TEMP_W-1:0] chan_hold [0:CH_NUM-1];
wire [1:0] chan_res [0:CH_NUM-1];
wire [7:0] chan_hi [0:CH_NUM-1];
wire [7:0] chan_lo [0:CH_NUM-1];

assign chan_hold[CH_LOC] = loc_hold;
assign chan_hold[CH_REM] = rem_hold;
assign chan_res[CH_LOC] = loc_res_sel;
// Remote fraction is not adjustable
assign chan_res[CH_REM] = `TRF_RES_SIXTEENTH;

genvar ch;
generate
   for (ch = 0; ch < CH_NUM; ch = ch + 1) begin : g_chan
      assign chan_hi[ch] = trf_high(chan_hold[ch], range_sel);
      assign chan_lo[ch] = trf_low(chan_hold[ch], chan_hi[ch], range_sel, chan_res[ch]);
   end
endgenerate

wire [7:0] loc_hi = chan_hi[CH_LOC];
wire [7:0] rem_hi = chan_hi[CH_REM];
wire [7:0] loc_lo = chan_lo[CH_LOC];
wire [7:0] rem_lo = chan_lo[CH_REM];

// Results and range latched together only on a completed conversion
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      loc_result <= 16'h0000;
      rem_result <= 16'h0000;
      range_used <= 1'b0;
   end else if (conv_take) begin
      loc_result <= {loc_hi, loc_lo};
      rem_result <= {rem_hi, rem_lo};
      range_used <= range_sel;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Limit comparison on stored high bytes against raw limit codes
// Limits are compared as written: software owns the format
wire [7:0] lh_lim = alarm_lim[31:24];
wire [7:0] ll_lim = alarm_lim[23:16];
wire [7:0] rh_lim = alarm_lim[15:8];
wire [7:0] rl_lim = alarm_lim[7:0];
wire loc_high = loc_result[15:8] > lh_lim;
wire loc_low = loc_result[15:8] < ll_lim;
wire rem_high = rem_result[15:8] > rh_lim;
wire rem_low = rem_result[15:8] < rl_lim;
wire loc_thermal_flag_output = loc_result[15:8] > thermal_flag_output_lim[15:8];
wire rem_thermal_flag_output = rem_result[15:8] > thermal_flag_output_lim[7:0];

reg conv_seen;
always @(posedge pclk or negedge presetn) begin
   if (!presetn)
      conv_seen <= 1'b0;
   else
      conv_seen <= conv_take;
end

wire [`TRF_ST_WIDTH-1:0] events = conv_seen ?
   {1'b1, rem_thermal_flag_output, loc_thermal_flag_output, rem_low, rem_high, loc_low, loc_high} :
   {`TRF_ST_WIDTH{1'b0}};

reg alarm_lvl, thermal_flag_output_lvl;
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      alarm_lvl <= 1'b0;
      thermal_flag_output_lvl <= 1'b0;
   end else if (conv_seen) begin
      alarm_lvl <= loc_high | loc_low | rem_high | rem_low;
      thermal_flag_output_lvl <= loc_thermal_flag_output | rem_thermal_flag_output;
   end
end

// Open-drain: the data is always low, only the enable moves
assign alarm_out = 1'b0;
assign alarm_oe = alarm_lvl;
assign thermal_flag_output = 1'b0;
assign thermal_flag_oe = thermal_flag_output_lvl;

////////////////////////////////////////////////////////////////////////////////
// APB write side; set beats write-one-to-clear
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      cfg <= `TRF_CFG_RESET;
      resol <= `TRF_RESOL_RESET;
      alarm_lim <= `TRF_ALARM_LIM_RESET;
      thermal_flag_output_lim <= `TRF_THERMAL_FLAG_OUTPUT_LIM_RESET;
      mask <= {`TRF_ST_WIDTH{1'b0}};
      status <= {`TRF_ST_WIDTH{1'b0}};
   end else begin
      // A range write touches only the config: limits stay as written
      if (wr_cfg) begin
         cfg <= pwdata[7:0];
      end
      if (wr_resol) begin
         resol <= pwdata[1:0];
      end
      if (wr_alarm) begin
         alarm_lim <= pwdata;
      end
      if (wr_thermal_flag_output) begin
         thermal_flag_output_lim <= pwdata[15:0];
      end
      if (wr_mask) begin
         mask <= pwdata[`TRF_ST_WIDTH-1:0];
      end
      // An event in the clearing cycle survives the clear
      if (wr_status) begin
         status <= (status & ~pwdata[`TRF_ST_WIDTH-1:0]) | events;
      end else begin
         status <= status | events;
      end
   end
end

assign irq = |(status & mask);

////////////////////////////////////////////////////////////////////////////////
// APB read data, registered on the setup cycle so it is valid in the access phase
always @(posedge pclk or negedge presetn) begin
   if (!presetn)
      prdata <= 32'h00000000;
   else if (psel && !penable && !pwrite) begin
      case (paddr)
         `TRF_OFS_CONFIG: prdata <= {24'h000000, cfg};
         `TRF_OFS_RESOL: prdata <= {30'h00000000, resol};
         `TRF_OFS_LOC_RESULT: prdata <= {15'h0000, range_used, loc_result};
         `TRF_OFS_REM_RESULT: prdata <= {15'h0000, range_used, rem_result};
         `TRF_OFS_ALARM_LIM: prdata <= alarm_lim;
         `TRF_OFS_THERMAL_FLAG_OUTPUT_LIM: prdata <= {16'h0000, thermal_flag_output_lim};
         `TRF_OFS_STATUS: prdata <= {25'h0000000, status};
         `TRF_OFS_MASK: prdata <= {25'h0000000, mask};
         default: prdata <= 32'h00000000;
      endcase
   end
end

endmodule // trf_formatter

// >>> testbench/trf_formatter_chk.sv
// Port checker for the temperature result formatter
`timescale 1ns/100ps
module trf_formatter_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire conv_done,
   input wire alarm_out,
   input wire alarm_oe,
   input wire thermal_flag_output,
   input wire thermal_flag_oe
);
   // Cycles since the link last flagged a conversion, saturating
   reg [3:0] since;
   wire rd = psel && penable && !pwrite;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) since <= 4'hF;
      else since <= conv_done ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_alarm_line_low: assert property (alarm_out == 1'b0)
      else $error("alarm data high");
   a_thermal_flag_output_line_low: assert property (thermal_flag_output == 1'b0)
      else $error("thermal data high");
   a_unmapped_err: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
      else $error("no error on unmapped");
   a_unmapped_zero: assert property (rd && pslverr |-> prdata == 32'h0)
      else $error("unmapped read nonzero");
   a_frac_low_zero: assert property (rd && paddr[11:3] == 9'h001 |-> prdata[3:0] == 4'h0)
      else $error("result low nibble set");
   a_std_top_clear: assert property (rd && paddr[11:3] == 9'h001 && !prdata[16] |-> !prdata[15])
      else $error("standard code above 7F");
   a_alarm_after_conv: assert property ($rose(alarm_oe) |-> since < 4'h8)
      else $error("alarm without conversion");
   a_thermal_flag_output_after_conv: assert property ($rose(thermal_flag_oe) |-> since < 4'h8)
      else $error("thermal flag without conversion");
endmodule // trf_formatter_chk
bind trf_formatter trf_formatter_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .prdata, .pslverr, .conv_done, .alarm_out, .alarm_oe, .thermal_flag_output, .thermal_flag_oe);

// >>> testbench/trf_conv_model.sv
// Converter link model: one frame per conversion, clock still between frames
`timescale 1ns/100ps
module trf_conv_model (
   output logic conv_clk,
   output logic conv_done,
   output logic [12:0] local_temp,
   output logic [12:0] remote_temp
);
   initial begin
      conv_clk = 0;
      conv_done = 0;
      local_temp = 13'h0AAA;
      remote_temp = 13'h1555;
   end
   // Outside a frame the data lines show the inverse, not stale values
   task convert(input logic [12:0] l, input logic [12:0] r);
      local_temp = l;
      remote_temp = r;
      conv_done = 1;
      #37 conv_clk = 1;
      #80 conv_clk = 0;
      conv_done = 0;
      local_temp = ~l;
      remote_temp = ~r;
      #43;
   endtask
endmodule // trf_conv_model

// >>> testbench/trf_formatter_tb.sv
// Self-checking bench for the temperature result formatter
`timescale 1ns/100ps
module trf_formatter_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ext = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, seed = 32'h7B38641B, lim = 32'h0000FF00;
   logic [15:0] th = 16'h7F7F;
   logic [1:0] res = 2'h3;
   logic [31:0] exp_q[$];
   logic [12:0] tv[8] = '{13'h1FF0, 13'h07F8, 13'h0800, 13'h0192, 13'h1C00, 13'h0FFF, 13'h0, 13'h0018};
   wire [31:0] prdata;
   wire pready, pslverr, conv_clk, conv_done, alarm_oe, thermal_flag_oe, irq;
   wire [12:0] local_temp, remote_temp;
   int fail_count = 0, total_checks = 0;
   trf_formatter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .conv_clk, .conv_done, .local_temp, .remote_temp, .alarm_out(),
      .alarm_oe, .thermal_flag_output(), .thermal_flag_oe, .irq);
   trf_conv_model m (.conv_clk, .conv_done, .local_temp, .remote_temp);
   initial forever #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] fmt(input logic [12:0] t, input logic [1:0] r);
      int v;
      logic [7:0] h;
      logic [3:0] f;
      v = $signed(t[12:4]) + (ext ? 64 : 0);
      f = t[3:0] & {1'b1, r > 0, r > 1, r > 2};
      h = v[7:0];
      if (v < 0) begin h = 0; f = 0; end
      else if (v > (ext ? 255 : 127)) h = ext ? 8'hFF : 8'h7F;
      return {15'h0, ext, h, f, 4'h0};
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %0t saw %h want %h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      {psel, penable} <= 2'b00;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(0, a, 0);
   endtask
   always @(posedge pclk) if (psel && penable && pready && !pwrite) chk(prdata, exp_q.pop_front());
   task cv(input logic [12:0] l, input logic [12:0] r);
      logic [31:0] el, er;
      logic [6:0] s;
      el = fmt(l, res);
      er = fmt(r, 2'h3);
      s = {1'b1, er[15:8] > th[7:0], el[15:8] > th[15:8], er[15:8] < lim[7:0],
         er[15:8] > lim[15:8], el[15:8] < lim[23:16], el[15:8] > lim[31:24]};
      apb(1, 12'h018, 32'h7F);
      m.convert(l, r);
      repeat (4) @(posedge pclk);
      rd(12'h008, el);
      rd(12'h00C, er);
      rd(12'h018, {25'h0, s});
      chk(alarm_oe, |s[3:0]);
      chk(thermal_flag_oe, |s[5:4]);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      end_sim;
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      rd(12'h0, 0); rd(12'h004, 3); rd(12'h010, lim); rd(12'h014, th); rd(12'h01C, 0);
      rd(12'h020, 0);
      lim = 32'h40105005; th = 16'h6070;
      apb(1, 12'h010, lim); apb(1, 12'h014, th);
      for (int i = 0; i < 8; i++) cv(tv[i], tv[7 - i]);
      repeat (4) begin seed = lfsr(seed); cv(seed[12:0], seed[28:16]); end
      for (int i = 0; i < 4; i++) begin res = i; apb(1, 12'h004, i); cv(13'h032F, 13'h1FF7); end
      apb(1, 12'h0, 32'h4);
      rd(12'h008, fmt(13'h032F, 2'h3));
      rd(12'h010, lim);
      ext = 1;
      rd(12'h0, 4);
      lim = 32'h80509060; th = 16'hA0B0;
      apb(1, 12'h010, lim); apb(1, 12'h014, th);
      for (int i = 0; i < 8; i++) cv(tv[i], tv[(i + 3) % 8]);
      cv(13'h1C08, 13'h1BF8);
      #1 chk(irq, 0);
      apb(1, 12'h01C, 32'h40);
      @(posedge pclk) #1 chk(irq, 1);
      apb(1, 12'h018, 32'h7F);
      @(posedge pclk) #1 chk(irq, 0);
      end_sim;
   end
endmodule // trf_formatter_tb
